/* verilog/swire_host_pkg.sv */
// constants and types for the single-wire bus host controller
package swire_host_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;

    // ------------------------------------------------------------
    // bus times in ns, chosen inside the device's windows
    // ------------------------------------------------------------
    localparam int RESET_LOW_TIME_NS = 50000;
    localparam int RESET_HIGH_TIME_NS = 50000;
    localparam int PRESENCE_SAMPLE_TIME_NS = 8000;
    localparam int WRITE_ZERO_LOW_TIME_NS = 8000;
    localparam int WRITE_ONE_LOW_TIME_NS = 1000;
    localparam int READ_LOW_TIME_NS = 500;
    localparam int READ_SAMPLE_TIME_NS = 1500;
    localparam int RECOVERY_TIME_NS = 5000;
    localparam int LOW_LIMIT_NS = 16000;

    // ------------------------------------------------------------
    // cycle counts: least times round up, longest round down
    // ------------------------------------------------------------
    localparam int RSTL_CYC = (RESET_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int RSTH_CYC = (RESET_HIGH_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int MSP_CYC = (PRESENCE_SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int W0_CYC = (WRITE_ZERO_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int W1_CYC = (WRITE_ONE_LOW_TIME_NS * CLK_MHZ) / 1000;
    localparam int RL_CYC = (READ_LOW_TIME_NS * CLK_MHZ) / 1000;
    localparam int MSR_CYC = (READ_SAMPLE_TIME_NS * CLK_MHZ) / 1000;
    localparam int REC_CYC = (RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int LOW_LIMIT_CYC = (LOW_LIMIT_NS * CLK_MHZ) / 1000;
    localparam int SLOT_CYC = W0_CYC + REC_CYC;

    localparam int CNT_W = 16;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    // ------------------------------------------------------------
    // commands and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_RESET = 3'b000,
        OP_WBIT = 3'b001,
        OP_RBIT = 3'b010,
        OP_WBYTE = 3'b011,
        OP_RBYTE = 3'b100,
        OP_TRIPLET = 3'b101
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RST_LOW = 2'b01,
        ST_RST_HIGH = 2'b10,
        ST_SLOT = 2'b11
    } state_t;

endpackage

/* verilog/swire_host.sv */
// bus master for a single open-drain wire, bit/byte/search-triplet engine
// How it works
// [RULE_01] line only pulled low, never driven high
// [RULE_02] slots last at least the overdrive slot
// [RULE_03] line released high whenever engine idles
// [RULE_04] no low over 16us except reset
// [RULE_05] order reset, rom, function, data: user
// [RULE_06] every transaction opens with reset pulse
// [RULE_07] master makes every slot falling edge
// [RULE_08] reset low includes margin for fall time
// [RULE_09] device answers presence after reset release
// [RULE_10] presence sampled low at sample time
// [RULE_11] slots start only after reset high time
// [RULE_12] one bit per slot, both directions
// [RULE_13] device times slots from falling edge
// [RULE_14] write-one released before its low limit
// [RULE_15] write-zero held low past its minimum
// [RULE_16] recovery kept after line rises high
// [RULE_17] read slot opens like write-one
// [RULE_18] device pulls low to return zero
// [RULE_19] device leaves line alone to return one
// [RULE_20] data refused until presence was seen
// [RULE_21] crc-16 over function data both ways
// [RULE_22] device never starts a slot itself
// [RULE_23] rom commands are eight-bit codes
// [RULE_24] match compares 64-bit identifier
// [RULE_25] resume relies on device resume_flag
// [RULE_26] search triplet: bit, complement, choice
// [RULE_27] reset abandons transaction, yields presence
`timescale 1ns/10ps
`default_nettype none

module swire_host
    import swire_host_pkg::*;
#(
    parameter int RSTL_CYCLES = RSTL_CYC,
    parameter int RSTH_CYCLES = RSTH_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic refused_o,
    output logic [7:0] rdata_o,
    output logic presence_o,
    input wire logic crc_clear_i,
    output logic [15:0] crc_o,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_n_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0] op_ff;
    logic [7:0] sh_ff;
    logic [3:0] bits_ff;
    logic low_ff;
    logic zero_ff;
    logic rbit_ff;
    logic id_ff;
    logic cmp_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic presence_ff;
    logic done_ff;
    logic refused_ff;
    logic [7:0] rdata_ff;
    logic [15:0] crc_ff;

    logic line_hi;
    logic take;
    logic data_op;
    logic slot_read;
    logic [CNT_W-1:0] low_len;
    logic slot_end;
    logic cur_bit;
    logic trip_dir;

    assign line_hi = sync2_ff;
    assign cmd_ready_o = (state_ff == ST_IDLE);
    assign take = cmd_valid_i && cmd_ready_o; // RULE_05
    assign data_op = (cmd_op_i != OP_RESET);
    assign done_o = done_ff;
    assign refused_o = refused_ff;
    assign rdata_o = rdata_ff;
    assign presence_o = presence_ff;
    assign crc_o = crc_ff;
    assign line_o = 1'b0; // RULE_01
    assign line_oe_n_o = ~low_ff; // RULE_03

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= line_i;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------
    // slot shape
    // ------------------------------------------------------------
    // read slots (and the first two triplet slots) release early
    assign slot_read = (op_ff == OP_RBIT) || (op_ff == OP_RBYTE) ||
        ((op_ff == OP_TRIPLET) && (bits_ff != 4'h1));
    assign low_len = zero_ff ? CNT_W'(W0_CYC) :
        (slot_read ? CNT_W'(RL_CYC) : CNT_W'(W1_CYC)); // RULE_04
    // waiting for line high stretches recovery past a slow rise
    assign slot_end = (cnt_ff >= CNT_W'(SLOT_CYC - 1)) && line_hi; // RULE_16
    assign cur_bit = slot_read ? rbit_ff : sh_ff[0];
    // complement is still in rbit_ff when the direction is chosen
    assign trip_dir = (id_ff == rbit_ff) ? cmd_data_i[0] : id_ff; // RULE_26

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            op_ff <= OP_RESET;
            sh_ff <= 8'h00;
            bits_ff <= 4'h0;
            low_ff <= 1'b0;
            zero_ff <= 1'b0;
            rbit_ff <= 1'b1;
            id_ff <= 1'b0;
            cmp_ff <= 1'b0;
            presence_ff <= 1'b0;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= '0;
                    if (take && data_op && !presence_ff) begin
                        refused_ff <= 1'b1; // RULE_20
                    end else if (take && !data_op) begin
                        state_ff <= ST_RST_LOW; // RULE_06 RULE_27
                        presence_ff <= 1'b0;
                        low_ff <= 1'b1;
                        op_ff <= cmd_op_i;
                    end else if (take) begin
                        state_ff <= ST_SLOT; // RULE_07 RULE_12
                        op_ff <= cmd_op_i;
                        low_ff <= 1'b1;
                        case (cmd_op_i)
                            OP_WBYTE: begin
                                sh_ff <= cmd_data_i;
                                bits_ff <= 4'h8; // RULE_23
                                zero_ff <= ~cmd_data_i[0];
                            end
                            OP_RBYTE: begin
                                sh_ff <= 8'hff;
                                bits_ff <= 4'h8;
                                zero_ff <= 1'b0;
                            end
                            OP_TRIPLET: begin
                                sh_ff <= 8'hff;
                                bits_ff <= 4'h3;
                                zero_ff <= 1'b0;
                            end
                            OP_WBIT: begin
                                sh_ff <= {7'h00, cmd_data_i[0]};
                                bits_ff <= 4'h1;
                                zero_ff <= ~cmd_data_i[0];
                            end
                            default: begin
                                sh_ff <= 8'hff;
                                bits_ff <= 4'h1;
                                zero_ff <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_RST_LOW: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    // margin above the minimum covers a slewed fall
                    if (cnt_ff == CNT_W'(RSTL_CYCLES - 1)) begin // RULE_08
                        low_ff <= 1'b0;
                        cnt_ff <= '0;
                        state_ff <= ST_RST_HIGH;
                    end
                end
                ST_RST_HIGH: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (cnt_ff == CNT_W'(MSP_CYC)) begin
                        presence_ff <= ~line_hi; // RULE_10 RULE_09
                    end
                    if ((cnt_ff >= CNT_W'(RSTH_CYCLES - 1)) && line_hi) begin
                        state_ff <= ST_IDLE; // RULE_11
                        done_ff <= 1'b1;
                        rdata_ff <= {7'h00, presence_ff};
                    end
                end
                ST_SLOT: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (low_ff && (cnt_ff == low_len - 1'b1)) begin
                        low_ff <= 1'b0; // RULE_14 RULE_15 RULE_17
                    end
                    if (cnt_ff == CNT_W'(MSR_CYC)) begin
                        rbit_ff <= line_hi; // RULE_18 RULE_19 RULE_13
                    end
                    if (slot_end) begin // RULE_02
                        cnt_ff <= '0;
                        sh_ff <= {cur_bit, sh_ff[7:1]};
                        bits_ff <= bits_ff - 1'b1;
                        if ((op_ff == OP_TRIPLET) && (bits_ff == 4'h3)) begin
                            id_ff <= rbit_ff;
                        end
                        if ((op_ff == OP_TRIPLET) && (bits_ff == 4'h2)) begin
                            cmp_ff <= rbit_ff;
                        end
                        if (bits_ff == 4'h1) begin
                            state_ff <= ST_IDLE;
                            done_ff <= 1'b1;
                            if ((op_ff == OP_WBYTE) || (op_ff == OP_RBYTE)) begin
                                rdata_ff <= {cur_bit, sh_ff[7:1]};
                            end else if (op_ff == OP_TRIPLET) begin
                                rdata_ff <= {4'h0, id_ff & cmp_ff,
                                    sh_ff[0], cmp_ff, id_ff};
                            end else begin
                                rdata_ff <= {7'h00, cur_bit};
                            end
                        end else begin
                            low_ff <= 1'b1;
                            if ((op_ff == OP_TRIPLET) && (bits_ff == 4'h2)) begin
                                sh_ff <= {7'h7f, trip_dir};
                                zero_ff <= ~trip_dir;
                            end else if (op_ff == OP_WBYTE) begin
                                zero_ff <= ~sh_ff[1];
                            end else begin
                                zero_ff <= 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    low_ff <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // crc-16 over byte traffic
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i || crc_clear_i) begin
            crc_ff <= CRC_INIT;
        end else if ((state_ff == ST_SLOT) && slot_end &&
            ((op_ff == OP_WBYTE) || (op_ff == OP_RBYTE))) begin
            crc_ff <= (crc_ff >> 1) ^
                ((crc_ff[0] ^ cur_bit) ? CRC_POLY : 16'h0000); // RULE_21
        end
    end

    // ------------------------------------------------------------
    // assertion helpers
    // ------------------------------------------------------------
    logic [CNT_W-1:0] low_run_ff;
    logic [CNT_W-1:0] hi_run_ff;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            low_run_ff <= '0;
            hi_run_ff <= '0;
        end else begin
            low_run_ff <= low_ff ? low_run_ff + 1'b1 : '0;
            if (low_ff || !line_hi) begin
                hi_run_ff <= '0;
            end else if (hi_run_ff != '1) begin
                hi_run_ff <= hi_run_ff + 1'b1;
            end
        end
    end

    sequence s_slot_release;
        (state_ff == ST_SLOT) && $fell(low_ff);
    endsequence

    sequence s_reset_release;
        (state_ff == ST_RST_HIGH) && $fell(low_ff);
    endsequence

    chk_low_limit: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (low_ff && state_ff != ST_RST_LOW) |->
        low_run_ff < CNT_W'(LOW_LIMIT_CYC)) // RULE_04
        else $error("non-reset low exceeds limit");

    chk_reset_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_reset_release |-> $past(low_run_ff) == CNT_W'(RSTL_CYCLES - 1))
        // RULE_06
        else $error("reset pulse length wrong");

    chk_zero_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_slot_release and zero_ff |->
        $past(low_run_ff) == CNT_W'(W0_CYC - 1)) // RULE_15
        else $error("write-zero low length wrong");

    chk_one_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_slot_release and !zero_ff |->
        $past(low_run_ff) <= CNT_W'(W1_CYC - 1)) // RULE_14
        else $error("write-one or read low too long");

    chk_slot_gap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_ff == ST_SLOT) && $rose(low_ff) && $past(state_ff) == ST_SLOT
        |-> $past(hi_run_ff) >= CNT_W'(REC_CYC - 3)) // RULE_16
        else $error("slot started inside recovery");

    chk_idle_free: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_ff == ST_IDLE |-> line_oe_n_o && line_o == 1'b0) // RULE_03
        else $error("line held while idle");

    chk_refuse_data: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && data_op && !presence_ff |=>
        refused_o && state_ff == ST_IDLE) // RULE_20
        else $error("data op taken without presence");

    chk_reset_gap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && $past(state_ff) == ST_RST_HIGH |->
        $past(cnt_ff) >= CNT_W'(RSTH_CYCLES - 1)) // RULE_11
        else $error("reset finished too early");

    chk_read_release: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_ff == ST_SLOT) && slot_read && cnt_ff >= CNT_W'(RL_CYC)
        |-> !low_ff) // RULE_17
        else $error("read slot held low past read time");

endmodule

`default_nettype wire

/* bench/swire_dev_model.sv */
// behavioural model of the single-wire slave device on the far side
`timescale 1ns/10ps
`default_nettype none

module swire_dev_model #(
    parameter int RST_DET_NS = 9000
) (
    input wire logic wire_i,
    input wire logic present_i,
    input wire logic talk_i,
    input wire logic [7:0] tx_i,
    output logic oe_n_o,
    output logic [7:0] rx_o
);
    logic [2:0] idx;
    logic pull;
    logic bit_s;
    realtime t0;

    // ------------------------------------------------------------
    // slot and reset handling
    // ------------------------------------------------------------
    // only ever pulls low, the bus pull-up makes the high level
    initial begin
        oe_n_o = 1'b1;
        rx_o = 8'h00;
        idx = 3'h0;
    end

    // acts only on host falling edges, never opens a slot itself
    always begin
        @(negedge wire_i);
        t0 = $realtime;
        pull = talk_i && !tx_i[idx];
        if (pull) begin
            oe_n_o = 1'b0;
            #2000;
            oe_n_o = 1'b1;
            #1000;
        end else begin
            #3000;
        end
        bit_s = wire_i;
        if (wire_i !== 1'b1) begin
            @(posedge wire_i);
        end
        if ($realtime - t0 > RST_DET_NS) begin
            idx = 3'h0;
            if (present_i) begin
                #4000;
                oe_n_o = 1'b0;
                #5000;
                oe_n_o = 1'b1;
            end
        end else begin
            if (!pull) begin
                rx_o = {bit_s, rx_o[7:1]};
            end
            idx = idx + 3'h1;
        end
    end
endmodule
`default_nettype wire

/* bench/tb_swire_host.sv */
// self-checking bench for the single-wire bus host
`timescale 1ns/10ps
`default_nettype none

module tb_swire_host;
    import swire_host_pkg::*;

    localparam int RSTL_SIM = 2500;
    localparam int RSTH_SIM = 2500;

    typedef struct packed {
        logic refused;
        logic [7:0] rdata;
    } note_t;

    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [7:0] cmd_data = 8'h00;
    logic crc_clear = 1'b0;
    logic cmd_ready, done, refused, presence, line_o, line_oe_n, dev_oe_n;
    logic [7:0] rdata, dev_rx;
    logic [15:0] crc;
    logic present = 1'b0;
    logic talk = 1'b0;
    logic [7:0] tx = 8'h00;
    wire line;
    note_t notes[$];
    note_t n;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    int nfall = 0;
    int seed = 76;
    logic [7:0] wb;
    logic [15:0] crc_exp;
    logic b;

    // pull-up with two open-drain parties
    assign line = (line_oe_n ? 1'b1 : line_o) & dev_oe_n;

    swire_host #(.RSTL_CYCLES(RSTL_SIM), .RSTH_CYCLES(RSTH_SIM)) DUT (
        .core_clk_i(core_clk), .reset_i(reset), .cmd_valid_i(cmd_valid),
        .cmd_op_i(cmd_op), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
        .done_o(done), .refused_o(refused), .rdata_o(rdata),
        .presence_o(presence), .crc_clear_i(crc_clear), .crc_o(crc),
        .line_i(line), .line_o(line_o), .line_oe_n_o(line_oe_n)
    );

    swire_dev_model dev (
        .wire_i(line), .present_i(present), .talk_i(talk), .tx_i(tx),
        .oe_n_o(dev_oe_n), .rx_o(dev_rx)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reflected crc over one byte, lsb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic fb;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ d[i];
            c = c >> 1;
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    task automatic run(input logic [2:0] op, input logic [7:0] d,
                       input logic r, input logic [7:0] e);
        int k;
        @(negedge core_clk);
        notes.push_back('{r, e});
        cmd_op = op;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && refused !== 1'b1 && k < 40000) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
    endtask

    // ------------------------------------------------------------
    // monitor and watchdog
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        if (done === 1'b1 || refused === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected answer", 16'h0001, 16'h0000);
            end else begin
                n = notes.pop_front();
                check("refused", {15'h0, refused}, {15'h0, n.refused});
                if (!n.refused) begin
                    check("rdata", {8'h00, rdata}, {8'h00, n.rdata});
                end
            end
        end
    end

    always @(negedge line_oe_n) begin
        nfall++;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 99500) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        check("ready after reset", {15'h0, cmd_ready}, 16'h0001);
        check("wire released", {15'h0, line_oe_n}, 16'h0001);
        check("crc after reset", crc, 16'h0000);
        run(OP_WBIT, 8'h00, 1'b1, 8'h00);
        check("no wire activity", nfall[15:0], 16'h0000);
        run(OP_RESET, 8'h00, 1'b0, 8'h00);
        present = 1'b1;
        run(OP_RESET, 8'h00, 1'b0, 8'h01);
        check("presence level", {15'h0, presence}, 16'h0001);
        wb = 8'($random(seed));
        run(OP_WBYTE, wb, 1'b0, wb);
        check("device got byte", {8'h00, dev_rx}, {8'h00, wb});
        crc_exp = crc_byte(CRC_INIT, wb);
        check("crc write", crc, crc_exp);
        talk = 1'b1;
        tx = 8'($random(seed));
        run(OP_RBYTE, 8'h00, 1'b0, tx);
        crc_exp = crc_byte(crc_exp, tx);
        check("crc read", crc, crc_exp);
        run(OP_RBIT, 8'h00, 1'b0, {7'h00, tx[0]});
        talk = 1'b0;
        for (int i = 0; i < 2; i++) begin
            run(OP_WBIT, 8'(i), 1'b0, 8'(i));
            check("device got bit", {15'h0, dev_rx[7]}, 16'(i));
        end
        check("crc kept by bits", crc, crc_exp);
        @(negedge core_clk);
        crc_clear = 1'b1;
        @(negedge core_clk);
        crc_clear = 1'b0;
        @(negedge core_clk);
        check("crc cleared", crc, 16'h0000);
        run(OP_RESET, 8'h00, 1'b0, 8'h01);
        talk = 1'b1;
        b = 1'($random(seed));
        tx = {6'h3f, ~b, b};
        run(OP_TRIPLET, 8'hfe, 1'b0, {5'h00, b, ~b, b});
        check("search branch", {15'h0, dev_rx[7]}, {15'h0, b});
        tx = 8'hff;
        b = 1'($random(seed));
        run(OP_TRIPLET, {7'h00, b}, 1'b0, {5'h01, b, 2'b11});
        check("search choice", {15'h0, dev_rx[7]}, {15'h0, b});
        conclude();
    end
endmodule
`default_nettype wire
